// File: logic/frmbc_fifo.sv
// Purpose: word buffer between array fetch and burst output
// Assumes: clr_i empties the buffer in one cycle
// Notes:   full and empty come from pointers with a wrap bit
module frmbc_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk_i,       // clock
  input  wire logic         srst_i,      // sync reset
  input  wire logic         clr_i,       // flush
  input  wire logic         in_valid_i,  // write request
  output logic              in_ready_o,  // not full
  input  wire logic [W-1:0] in_data_i,   // write word
  output logic              out_valid_o, // not empty
  input  wire logic         out_ready_i, // read accept
  output logic [W-1:0]      out_data_o   // head word
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r, wp_nxt;
  logic [AW:0]  rp_r, rp_nxt;
  logic         full, empty, push, pop;

  assign full        = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty       = (wp_r == rp_r);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_r[rp_r[AW-1:0]];
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (clr_i) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end else begin
      if (push) wp_nxt = wp_r + 1'b1;
      if (pop)  rp_nxt = rp_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (push && !clr_i) mem_r[wp_r[AW-1:0]] <= in_data_i;
  end

  a_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (srst_i)
    full && !pop && !clr_i |=> wp_r == $past(wp_r))
    else $error("fifo pointer moved while full");
endmodule

// File: logic/frmbc_pkg.sv
// Purpose: shared constants and types for the flash read-mode and burst block
// Assumes: 22-bit word address, 16-bit multiplexed data, eight banks
// Notes:   configuration word layout and command codes live here only
package frmbc_pkg;

  localparam int ADDR_W   = 22;
  localparam int DATA_W   = 16;
  localparam int NBANK    = 8;
  localparam int BANK_LSB = 19;
  localparam int SECT_LSB = 15;
  localparam int SECT_W   = ADDR_W - SECT_LSB;
  localparam int FIFO_D   = 8;

  // command cycles
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002aa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [ADDR_W-1:0] CMD_ADDR     = 22'h000555;
  localparam logic [DATA_W-1:0] CFG_LOAD_CMD = 16'h00d0;
  localparam logic [DATA_W-1:0] CFG_READ_CMD = 16'h00c6;
  localparam logic [ADDR_W-1:0] CFG_ADDR     = 22'h000000;
  localparam logic [DATA_W-1:0] RESET_CMD    = 16'h00f0;
  localparam logic [DATA_W-1:0] STATUS_WORD  = 16'h0000;

  // burst_configuration layout and reset value
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h2f88;
  localparam int LAT_LSB  = 11;
  localparam int POL_BIT  = 10;
  localparam int TIM_BIT  = 8;
  localparam int WRAP_BIT = 3;
  localparam int LEN_LSB  = 0;
  localparam logic [5:0] LAT_BASE = 6'h02;

  localparam logic [2:0] LAT_MIN  = 3'h0;
  localparam logic [2:0] BL_CONT  = 3'h0;
  localparam logic [2:0] BL_8     = 3'h2;
  localparam logic [2:0] BL_16    = 3'h3;
  localparam logic [2:0] BL_32    = 3'h4;

  typedef enum logic [2:0] {
    CS_IDLE     = 3'b000,
    CS_UNL1     = 3'b001,
    CS_UNL2     = 3'b010,
    CS_CFG_LOAD = 3'b011,
    CS_CFG_READ = 3'b100
  } frmbc_cmd_t;

  typedef enum logic [2:0] {
    BM_READ  = 3'b000,
    BM_ESUSP = 3'b001,
    BM_PSUSP = 3'b010,
    BM_BUSY  = 3'b011,
    BM_ASEL  = 3'b100
  } frmbc_bmode_t;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              avd_n;
    logic              bclk;
    logic [5:0]        addr_hi;
    logic [DATA_W-1:0] adq;
  } frmbc_bus_t;

  typedef struct packed {
    logic              start;
    logic              done;
    logic              erase;
    logic              esusp;
    logic              psusp;
    logic              asel;
    logic [2:0]        bank;
    logic [SECT_W-1:0] sect;
  } frmbc_evt_t;

endpackage

// File: logic/frmbc_top.sv
// Purpose: read-mode tracking, command decode and burst engine of a muxed flash
// Assumes: host pins sampled on ref_clk_i; array answers one cycle after a request
// Notes:   burst clock pin is sampled and its rising edge used as an enable
// Overview of operation
// - power-up leaves banks in read-array mode
// - bank returns to read after embedded op
// - erase suspend enters suspend-read, serves other sectors
// - program suspend serves other sectors of bank
// - no burst before configuration loaded
// - reset restores configuration defaults, asynchronous mode
// - config frozen during program, erase, lock
// - config read sequence returns register at 000h; code returns it at any address read after the sequence
// - wait field sets latency two to nine
// - latency two forces ready with data
// - length field selects continuous or 8/16/32
// - continuous burst increments, wraps at top
// - linear wrap stays inside aligned block
// - wrap bit defaults one, zero disables wrap
// - ready timing bit: with or before data
// - ready polarity bit selects active level
// - ready asserted while burst data valid
// - wrap reads one in continuous mode
// - address on strobe rise, data on write rise
// - bad command cycle aborts to read-array
module frmbc_top
  import frmbc_pkg::*;
(
  input  wire logic                     ref_clk_i,          // 20 MHz clock
  input  wire logic                     srst_i,             // sync reset, high
  input  wire frmbc_bus_t               bus_i,              // host pins
  input  wire frmbc_evt_t               evt_i,              // embedded op events
  input  wire logic [NBANK-1:0]         timeout_flag_bit_i, // per-bank timeout
  input  wire logic [DATA_W-1:0]        arr_data_i,         // array word
  input  wire logic                     arr_vld_i,          // array word valid
  output logic                          arr_req_o,          // array read request
  output logic [ADDR_W-1:0]             arr_addr_o,         // array read address
  output logic [DATA_W-1:0]             adq_o,              // data out
  output logic                          adq_oe_o,           // data drive enable
  output logic                          rdy_o,              // ready pin level
  output logic                          sync_mode_o         // burst mode armed
);

  function automatic logic rd_ok(frmbc_bmode_t m, logic [SECT_W-1:0] s,
                                 logic [ADDR_W-1:0] a);
    logic ok;
    ok = 1'b0;
    unique case (m)
      BM_READ:            ok = 1'b1;
      BM_ESUSP, BM_PSUSP: ok = (a[ADDR_W-1:SECT_LSB] != s);
      default:            ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic [ADDR_W-1:0] next_addr(logic [ADDR_W-1:0] a,
                                                  logic [2:0] len, logic wrap);
    logic [ADDR_W-1:0] inc;
    logic [ADDR_W-1:0] msk;
    inc = a + 1'b1;
    msk = '0;
    unique case (len)
      BL_8:    msk = 22'h000007;
      BL_16:   msk = 22'h00000f;
      BL_32:   msk = 22'h00001f;
      default: msk = '0;
    endcase
    if (len != BL_CONT && wrap) return (a & ~msk) | (inc & msk);
    return inc;
  endfunction

  // pin edges and latches
  logic              we_q_r, we_q_nxt, avd_q_r, avd_q_nxt, bclk_q_r, bclk_q_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic              we_rise, avd_rise, bclk_rise;
  logic [ADDR_W-1:0] addr_in;

  assign we_rise   = !we_q_r && bus_i.we_n;
  assign avd_rise  = !avd_q_r && bus_i.avd_n;
  assign bclk_rise = !bclk_q_r && bus_i.bclk;
  assign addr_in   = {bus_i.addr_hi, bus_i.adq};

  always_comb begin
    we_q_nxt   = bus_i.we_n;
    avd_q_nxt  = bus_i.avd_n;
    bclk_q_nxt = bus_i.bclk;
    addr_nxt   = avd_rise ? addr_in : addr_r;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      we_q_r   <= 1'b1;
      avd_q_r  <= 1'b1;
      bclk_q_r <= 1'b0;
      addr_r   <= '0;
    end else begin
      we_q_r   <= we_q_nxt;
      avd_q_r  <= avd_q_nxt;
      bclk_q_r <= bclk_q_nxt;
      addr_r   <= addr_nxt;
    end
  end

  // per-bank read mode
  frmbc_bmode_t      mode_w [NBANK];
  logic [SECT_W-1:0] sect_w [NBANK];
  logic [NBANK-1:0]  busy_w;
  logic              any_busy, reset_cmd;

  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      frmbc_bmode_t      m_r, m_nxt;
      logic              esp_r, esp_nxt;
      logic [SECT_W-1:0] s_r, s_nxt;
      logic              hit;
      assign hit       = (evt_i.bank == 3'(g));
      assign mode_w[g] = m_r;
      assign sect_w[g] = s_r;
      assign busy_w[g] = (m_r == BM_BUSY);
      always_comb begin
        m_nxt   = m_r;
        esp_nxt = esp_r;
        s_nxt   = s_r;
        if (hit && evt_i.start) begin
          m_nxt = BM_BUSY;
        end else if (hit && evt_i.done) begin
          esp_nxt = esp_r && !evt_i.erase;
          m_nxt   = (esp_r && !evt_i.erase) ? BM_ESUSP : BM_READ;
        end else if (hit && evt_i.esusp) begin
          m_nxt   = BM_ESUSP;
          esp_nxt = 1'b1;
          s_nxt   = evt_i.sect;
        end else if (hit && evt_i.psusp) begin
          m_nxt = BM_PSUSP;
          s_nxt = evt_i.sect;
        end else if (hit && evt_i.asel) begin
          m_nxt = BM_ASEL;
        end else if (reset_cmd && (m_r == BM_ASEL || (m_r == BM_BUSY && timeout_flag_bit_i[g])))
        begin
          m_nxt = esp_r ? BM_ESUSP : BM_READ;
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          m_r   <= BM_READ;
          esp_r <= 1'b0;
          s_r   <= '0;
        end else begin
          m_r   <= m_nxt;
          esp_r <= esp_nxt;
          s_r   <= s_nxt;
        end
      end
    end
  endgenerate

  assign any_busy = |busy_w;

  // command decode and configuration register
  frmbc_cmd_t        cs_r, cs_nxt;
  logic [DATA_W-1:0] cr_r, cr_nxt;
  logic              loaded_r, loaded_nxt, sync_r, sync_nxt;
  logic [DATA_W-1:0] cr_rd;
  logic [2:0]        len;
  logic              wrap_eff;

  assign len      = cr_r[LEN_LSB +: 3];
  assign wrap_eff = cr_r[WRAP_BIT] || (len == BL_CONT);
  assign cr_rd    = {cr_r[DATA_W-1:WRAP_BIT+1], wrap_eff, cr_r[WRAP_BIT-1:0]};
  assign reset_cmd = we_rise && (cs_r != CS_CFG_LOAD) && (bus_i.adq == RESET_CMD);

  always_comb begin
    cs_nxt     = cs_r;
    cr_nxt     = cr_r;
    loaded_nxt = loaded_r;
    sync_nxt   = sync_r;
    if (reset_cmd) begin
      cs_nxt   = CS_IDLE;
      sync_nxt = loaded_r;
    end else if (we_rise) begin
      cs_nxt = CS_IDLE;
      unique case (cs_r)
        CS_IDLE: if (addr_r == UNLOCK1_ADDR && bus_i.adq == UNLOCK1_DATA) cs_nxt = CS_UNL1;
        CS_UNL1: if (addr_r == UNLOCK2_ADDR && bus_i.adq == UNLOCK2_DATA) cs_nxt = CS_UNL2;
        CS_UNL2: begin
          if (addr_r == CMD_ADDR && bus_i.adq == CFG_LOAD_CMD) cs_nxt = CS_CFG_LOAD;
          if (addr_r == CMD_ADDR && bus_i.adq == CFG_READ_CMD) cs_nxt = CS_CFG_READ;
        end
        CS_CFG_LOAD: begin
          if (addr_r == CFG_ADDR && !any_busy) begin
            cr_nxt     = bus_i.adq;
            loaded_nxt = 1'b1;
          end
        end
        CS_CFG_READ: cs_nxt = CS_IDLE;
        default:     cs_nxt = CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cs_r     <= CS_IDLE;
      cr_r     <= CFG_RESET;
      loaded_r <= 1'b0;
      sync_r   <= 1'b0;
    end else begin
      cs_r     <= cs_nxt;
      cr_r     <= cr_nxt;
      loaded_r <= loaded_nxt;
      sync_r   <= sync_nxt;
    end
  end

  // burst engine and pin outputs
  logic              burst_r, burst_nxt, pend_r, pend_nxt, req_r, req_nxt;
  logic              oe_r, oe_nxt, rdy_r, rdy_nxt, act;
  logic [5:0]        cnt_r, cnt_nxt;
  logic [5:0]        lat_n;
  logic [ADDR_W-1:0] fa_r, fa_nxt, ra_r, ra_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              tim_eff, clr, f_in_rdy, f_out_vld, pop, bank_ok;
  logic [DATA_W-1:0] f_data;

  assign lat_n   = {3'h0, cr_r[LAT_LSB +: 3]} + LAT_BASE;
  assign tim_eff = cr_r[TIM_BIT] || (cr_r[LAT_LSB +: 3] == LAT_MIN);
  assign bank_ok = rd_ok(mode_w[addr_in[ADDR_W-1:BANK_LSB]],
                         sect_w[addr_in[ADDR_W-1:BANK_LSB]], addr_in);

  always_comb begin
    burst_nxt = burst_r;
    pend_nxt  = pend_r && !arr_vld_i;
    req_nxt   = 1'b0;
    ra_nxt    = ra_r;
    fa_nxt    = fa_r;
    cnt_nxt   = cnt_r;
    dout_nxt  = dout_r;
    clr       = 1'b0;
    pop       = 1'b0;
    act       = rdy_r ^ !cr_r[POL_BIT];
    oe_nxt    = !bus_i.ce_n && !bus_i.oe_n;
    if (arr_vld_i && !burst_r) dout_nxt = arr_data_i;
    if (bus_i.ce_n) burst_nxt = 1'b0;
    if (avd_rise) begin
      burst_nxt = 1'b0;
      clr       = 1'b1;
      if (cs_r == CS_CFG_READ) begin
        dout_nxt = cr_rd;
      end else if (!bank_ok) begin
        dout_nxt = STATUS_WORD;
      end else if (sync_r) begin
        burst_nxt = 1'b1;
        fa_nxt    = addr_in;
        cnt_nxt   = '0;
      end else begin
        req_nxt  = 1'b1;
        ra_nxt   = addr_in;
        pend_nxt = 1'b1;
      end
    end else if (burst_r) begin
      if (!pend_r && f_in_rdy) begin
        req_nxt  = 1'b1;
        ra_nxt   = fa_r;
        fa_nxt   = next_addr(fa_r, len, wrap_eff);
        pend_nxt = 1'b1;
      end
      if (bclk_rise) begin
        cnt_nxt = (cnt_r == 6'h3f) ? cnt_r : cnt_r + 6'h01;
        // no sum here: a saturated count must stay in the data phase
        if (cnt_r >= lat_n - 6'h01) begin
          pop      = f_out_vld;
          act      = f_out_vld;
          if (f_out_vld) dout_nxt = f_data;
        end else begin
          act = !tim_eff && (cnt_r + 6'h02 >= lat_n);
        end
      end
    end
    if (!burst_nxt) act = 1'b1;
    rdy_nxt = cr_r[POL_BIT] ? act : !act;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      burst_r <= 1'b0;
      pend_r  <= 1'b0;
      req_r   <= 1'b0;
      ra_r    <= '0;
      fa_r    <= '0;
      cnt_r   <= '0;
      dout_r  <= '0;
      oe_r    <= 1'b0;
      rdy_r   <= 1'b1;
    end else begin
      burst_r <= burst_nxt;
      pend_r  <= pend_nxt;
      req_r   <= req_nxt;
      ra_r    <= ra_nxt;
      fa_r    <= fa_nxt;
      cnt_r   <= cnt_nxt;
      dout_r  <= dout_nxt;
      oe_r    <= oe_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  frmbc_fifo #(
    .W (DATA_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .srst_i      (srst_i),
    .clr_i       (clr),
    .in_valid_i  (arr_vld_i && burst_r),
    .in_ready_o  (f_in_rdy),
    .in_data_i   (arr_data_i),
    .out_valid_o (f_out_vld),
    .out_ready_i (pop),
    .out_data_o  (f_data)
  );

  assign arr_req_o   = req_r;
  assign arr_addr_o  = ra_r;
  assign adq_o       = dout_r;
  assign adq_oe_o    = oe_r;
  assign rdy_o       = rdy_r;
  assign sync_mode_o = sync_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  a_cfg_reset_dflt: assert property ($fell(srst_i) |-> cr_r == CFG_RESET && !sync_r)
    else $error("configuration not at default after reset");
  a_cfg_busy_hold: assert property (any_busy |=> cr_r == $past(cr_r))
    else $error("configuration changed during embedded op");
  a_burst_needs_cfg: assert property (burst_r |-> loaded_r && sync_r)
    else $error("burst without loaded configuration");
  a_wrap_forced: assert property (len == BL_CONT |-> cr_rd[WRAP_BIT])
    else $error("wrap bit not forced in continuous mode");
  a_cmd_abort: assert property (we_rise && cs_r == CS_UNL1 && bus_i.adq != RESET_CMD
    && bus_i.adq != UNLOCK2_DATA |=> cs_r == CS_IDLE)
    else $error("bad command cycle did not abort");
  a_addr_latch: assert property (avd_rise |=> addr_r == $past(addr_in))
    else $error("address not latched on strobe rise");
  a_bank_done: assert property (evt_i.done && evt_i.bank == 3'h0 && !evt_i.start
    && evt_i.erase |=> mode_w[0] == BM_READ)
    else $error("bank did not return to read");
  a_rdy_idle: assert property (!burst_r && !burst_nxt |=> rdy_o == $past(cr_r[POL_BIT]))
    else $error("idle ready level wrong");
  a_cont_step: assert property (burst_r && !avd_rise && req_nxt && len == BL_CONT
    |=> fa_r == ra_r + 22'h000001)
    else $error("continuous burst did not increment");
  a_pop_on_edge: assert property (pop |-> bclk_rise && cnt_r >= lat_n - 6'h01)
    else $error("burst word outside data phase");

  c_cfg_load: cover property (cs_r == CS_CFG_LOAD && we_rise && addr_r == CFG_ADDR);
  c_burst_pop: cover property (pop ##3 pop);
  c_susp_read: cover property (mode_w[0] == BM_ESUSP && req_r);
  c_wrap_8: cover property (burst_r && len == BL_8 && req_nxt && ra_nxt[2:0] == 3'h7);

endmodule

// File: testbench/frmbc_host.sv
// Purpose: host controller model driving the muxed flash pins
// Assumes: pins change 2 ns after a rising edge of ref_clk_i
// Notes:   burst clock is a third of ref_clk_i and runs only inside bursts
module frmbc_host
  import frmbc_pkg::*;
(
  input  wire logic ref_clk_i, // clock
  input  wire logic rdy_i,     // ready pin
  output frmbc_bus_t bus_o,    // host pins
  output logic       cap_o     // word taken this cycle
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    bus_o      = '1;
    bus_o.bclk = 1'b0;
    cap_o      = 1'b0;
  end

  task automatic step();
    @(posedge ref_clk_i);
    #2;
  endtask

  task automatic addr_ph(input logic [ADDR_W-1:0] a);
    step();
    bus_o.ce_n                = 1'b0;
    bus_o.avd_n               = 1'b0;
    {bus_o.addr_hi, bus_o.adq} = a;
    step();
    bus_o.avd_n = 1'b1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_ph(a);
    step();
    bus_o.adq  = d;
    bus_o.we_n = 1'b0;
    step();
    bus_o.we_n = 1'b1;
    step();
    bus_o.ce_n = 1'b1;
    bus_o.adq  = ~d; // released bus shows no stale data
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    addr_ph(a);
    step(); // hold the address through the edge that sees the strobe rise
    bus_o.oe_n = 1'b0;
    bus_o.adq  = ~bus_o.adq;
    repeat (5) step();
    cap_o = 1'b1;
    step();
    cap_o      = 1'b0;
    bus_o.oe_n = 1'b1;
    bus_o.ce_n = 1'b1;
  endtask

  task automatic unlock();
    wr(UNLOCK1_ADDR, UNLOCK1_DATA);
    wr(UNLOCK2_ADDR, UNLOCK2_DATA);
  endtask

  task automatic load_cfg(input logic [DATA_W-1:0] v);
    unlock();
    wr(CMD_ADDR, CFG_LOAD_CMD);
    wr(CFG_ADDR, v);
  endtask

  task automatic read_cfg();
    unlock();
    wr(CMD_ADDR, CFG_READ_CMD);
    rd(CFG_ADDR);
    wr(CFG_ADDR, RESET_CMD);
  endtask

  // ready-paced burst; tim low means ready leads data by one edge
  task automatic burst(input logic [ADDR_W-1:0] a, input int n, input logic pol,
                       input logic tim, output int first);
    int   k;
    int   got;
    logic r;
    logic rp;
    k     = 0;
    got   = 0;
    rp    = 1'b0;
    first = 0;
    addr_ph(a);
    step();
    bus_o.oe_n = 1'b0;
    bus_o.adq  = ~bus_o.adq;
    while (got < n && k < n + 12) begin
      k++;
      step();
      cap_o      = 1'b0;
      bus_o.bclk = 1'b1;
      step();
      bus_o.bclk = 1'b0;
      @(posedge ref_clk_i);
      r = (rdy_i === pol);
      if (r && first == 0) begin
        first = k;
      end
      if (tim ? r : rp) begin
        got++;
        #2 cap_o = 1'b1;
      end
      rp = r;
    end
    step();
    cap_o      = 1'b0;
    bus_o.oe_n = 1'b1;
    bus_o.ce_n = 1'b1;
  endtask
endmodule

// File: testbench/frmbc_top_tb.sv
// Purpose: self-checking bench for the read-mode and burst block
// Assumes: array answers one cycle after each request
// Notes:   bench tasks queue expected words, a monitor compares on capture
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module frmbc_top_tb
  import frmbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              ref_clk_i;
  logic              srst_i;
  frmbc_bus_t        bus;
  frmbc_evt_t        evt_i;
  logic [DATA_W-1:0] arr_data_i;
  logic              arr_vld_i;
  logic              arr_req_o;
  logic [ADDR_W-1:0] arr_addr_o;
  logic [DATA_W-1:0] adq_o;
  logic              adq_oe_o;
  logic              rdy_o;
  logic              sync_mode_o;
  logic              cap;
  logic [NBANK-1:0]  tof;
  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] exp_w;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                tbl[6][5] = '{'{5, 0, 1, 1, 1}, '{0, 2, 1, 0, 1},
                                   '{1, 3, 1, 0, 0}, '{2, 4, 1, 1, 0},
                                   '{3, 2, 0, 1, 1}, '{4, 0, 0, 0, 1}};

  frmbc_top dut (
    .ref_clk_i          (ref_clk_i),
    .srst_i             (srst_i),
    .bus_i              (bus),
    .evt_i              (evt_i),
    .timeout_flag_bit_i (tof),
    .arr_data_i         (arr_data_i),
    .arr_vld_i          (arr_vld_i),
    .arr_req_o          (arr_req_o),
    .arr_addr_o         (arr_addr_o),
    .adq_o              (adq_o),
    .adq_oe_o           (adq_oe_o),
    .rdy_o              (rdy_o),
    .sync_mode_o        (sync_mode_o)
  );

  frmbc_host host (
    .ref_clk_i (ref_clk_i),
    .rdy_i     (rdy_o),
    .bus_o     (bus),
    .cap_o     (cap)
  );

  function automatic logic [DATA_W-1:0] dat(input logic [ADDR_W-1:0] a);
    return a[15:0] ^ {10'h000, a[21:16]};
  endfunction

  function automatic logic [ADDR_W-1:0] rnd();
    logic [31:0] t;
    t = $urandom;
    return t[ADDR_W-1:0];
  endfunction

  function automatic logic [ADDR_W-1:0] exp_addr(input logic [ADDR_W-1:0] s, input int j,
                                                 input int len, input int wrp);
    logic [ADDR_W-1:0] m;
    m = (len == 2) ? 22'h000007 : (len == 3) ? 22'h00000f : (len == 4) ? 22'h00001f : 22'h0;
    if (m == 0 || wrp == 0) begin
      return s + ADDR_W'(j);
    end
    return (s & ~m) | ((s + ADDR_W'(j)) & m);
  endfunction

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    arr_vld_i  = 1'b0;
    arr_data_i = '0;
  end

  // array answers one cycle after each request
  always @(posedge ref_clk_i) begin
    arr_vld_i  <= arr_req_o;
    arr_data_i <= arr_req_o ? dat(arr_addr_o) : ~arr_data_i;
  end

  always @(posedge ref_clk_i) begin
    if (cap === 1'b1) begin
      `CHK(adq_oe_o, 1'b1)
      `CHK(q.size() > 0, 1'b1)
      if (q.size() > 0) begin
        exp_w = q.pop_front();
        `CHK(adq_o, exp_w)
      end
    end
  end

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic reset_dut();
    @(posedge ref_clk_i);
    #2 srst_i = 1'b1;
    repeat (10) @(posedge ref_clk_i);
    #2 srst_i = 1'b0;
  endtask

  task automatic rdx(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    q.push_back(e);
    host.rd(a);
  endtask

  // kind 0 start, 1 done, 2 erase suspend, 3 program suspend, 4 autoselect
  task automatic ev(input int k, input logic er, input logic [2:0] b);
    frmbc_evt_t e;
    e       = '0;
    e.start = (k == 0);
    e.done  = (k == 1);
    e.esusp = (k == 2);
    e.psusp = (k == 3);
    e.asel  = (k == 4);
    e.erase = er;
    e.bank  = b;
    e.sect  = {b, 4'h0};
    @(posedge ref_clk_i);
    #2 evt_i = e;
    @(posedge ref_clk_i);
    #2 evt_i = '0;
  endtask

  task automatic chk_default();
    logic [ADDR_W-1:0] r;
    r = rnd();
    `CHK(sync_mode_o, 1'b0)
    `CHK(rdy_o, 1'b1)
    rdx(r, dat(r));
    q.push_back(CFG_RESET);
    host.read_cfg();
    `CHK(sync_mode_o, 1'b0)
  endtask

  task automatic susp(input int k, input logic [2:0] b);
    logic [ADDR_W-1:0] a;
    a = {b, 4'h0, 15'h0010};
    ev(0, k == 2, b);
    rdx(a, STATUS_WORD);
    ev(k, 1'b0, b);
    rdx(a, STATUS_WORD);
    rdx(a | 22'h008000, dat(a | 22'h008000));
    if (k == 2) begin
      ev(0, 1'b0, b);
      ev(1, 1'b0, b);
      rdx(a, STATUS_WORD);
      rdx(a | 22'h008000, dat(a | 22'h008000));
    end
    ev(1, k == 2, b);
    rdx(a, dat(a));
  endtask

  task automatic run_burst(input int i);
    logic [DATA_W-1:0] v;
    logic [ADDR_W-1:0] st;
    logic              te;
    int                first;
    v  = {2'b00, 3'(tbl[i][0]), 1'(tbl[i][4]), 1'b1, 1'(tbl[i][3]), 1'b1, 3'b000,
          1'(tbl[i][2]), 3'(tbl[i][1])};
    te = (tbl[i][3] != 0) || (tbl[i][0] == 0);
    st = (i == 0) ? 22'h3ffffb : {17'(rnd() >> 5), 5'h1d};
    reset_dut();
    host.load_cfg(v);
    if (tbl[i][1] == 0) begin
      v[WRAP_BIT] = 1'b1;
    end
    q.push_back(v);
    host.read_cfg();
    `CHK(sync_mode_o, 1'b1)
    for (int j = 0; j < 10; j++) begin
      q.push_back(dat(exp_addr(st, j, tbl[i][1], tbl[i][2])));
    end
    host.burst(st, 10, 1'(tbl[i][4]), te, first);
    `CHK(first, tbl[i][0] + (te ? 2 : 1))
    `CHK(q.size() == 0, 1'b1)
    repeat (3) @(posedge ref_clk_i);
    `CHK(rdy_o, 1'(tbl[i][4]))
    $display("test burst %0d done", i);
  endtask

  initial begin
    srst_i = 1'b1;
    evt_i  = '0;
    tof    = '0;
    void'($urandom(77345));
    reset_dut();
    chk_default();
    $display("test defaults done");
    host.wr(UNLOCK1_ADDR, UNLOCK1_DATA);
    host.wr(UNLOCK2_ADDR, 16'h0077);
    host.wr(CMD_ADDR, CFG_READ_CMD);
    rdx(CFG_ADDR, dat(CFG_ADDR));
    $display("test abort done");
    susp(2, 3'd0);
    susp(3, 3'd3);
    tof = 8'h04;
    ev(0, 1'b0, 3'd2);
    rdx(22'h100020, STATUS_WORD);
    host.wr(CMD_ADDR, RESET_CMD);
    rdx(22'h100020, dat(22'h100020));
    tof = '0;
    ev(4, 1'b0, 3'd2);
    rdx(22'h100020, STATUS_WORD);
    host.wr(CMD_ADDR, RESET_CMD);
    rdx(22'h100020, dat(22'h100020));
    $display("test timeout done");
    ev(0, 1'b1, 3'd5);
    host.load_cfg(16'h0002);
    ev(1, 1'b1, 3'd5);
    q.push_back(CFG_RESET);
    host.read_cfg();
    $display("test busy done");
    for (int i = 0; i < 6; i++) begin
      run_burst(i);
    end
    reset_dut();
    chk_default();
    $display("test second reset done");
    summarize();
  end
endmodule
